// *** perf_event_counters.sv ***
// Contract
// - Event C0/00 counts each retired instruction
// - Fixed counter counts retired instructions exactly
// - Fixed control bit 0 or 1 enables
// - Global bit 32 gates fixed, order-independent
// - Event B1/01 adds micro-ops per thread
// - Events B7/BB match configs 1A6/1A7
// - Request-type bits 3,7-11 select requests
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module perf_event_counters
    import perf_event_pkg::*;
#(
    parameter int unsigned NPROG = 2,   // Programmable counters
    parameter int unsigned CNT_W = 48   // Counter width, 33 to 63
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Core events
    input  wire core_events_t ev,
    // AHB-Lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic [31:0]       hrdata,
    output logic              hresp
);

    localparam int unsigned NCNT = NPROG + 1;  // Slot 0 is fixed

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [1:0][63:0]       offCfg;     // Off-core match configs
    logic [63:0]            fixedCtrl;  // Fixed-counter control
    logic [63:0]            globalEn;   // Global enables
    logic [NPROG-1:0][63:0] evSel;      // Event selects
    logic [NCNT-1:0][CNT_W-1:0] cnt;    // Counter values

    // ****************************************************************
    // Bus slave state
    // ****************************************************************
    bus_state_t  state;      // Idle or read wait
    logic        wrPending;  // Write data phase now
    logic [9:0]  capIdx;     // Captured word index
    logic        capHi;      // Captured upper-half select
    logic        capOk;      // Captured address is in range
    wire  [31:0] rdWord;     // Addressed half, decoded further down

    // Address phase decode
    wire accept   = hsel && hready && htrans == HTRANS_NONSEQ;
    wire addrOk   = haddr[31:TOP_LSB] == '0 && hsize == SIZE_WORD;
    wire [9:0] aIdx = haddr[IDX_MSB:IDX_LSB];

    // Write strobes for the data phase
    wire wrLive   = wrPending && capOk;
    wire wrCfg0   = wrLive && capIdx == IDX_OFFCORE_CFG0;
    wire wrCfg1   = wrLive && capIdx == IDX_OFFCORE_CFG1;
    wire wrFixCtl = wrLive && capIdx == IDX_FIXED_CTRL;
    wire wrGlobal = wrLive && capIdx == IDX_GLOBAL_EN;
    wire wrFixCnt = wrLive && capIdx == IDX_FIXED_CTR;

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    // Reads take one wait state so that hrdata leaves a flop and any
    // write in the previous data phase is already visible
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state     <= BUS_IDLE;
            wrPending <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= RESET_WORD;
            hresp     <= 1'b0;
            capIdx    <= '0;
            capHi     <= 1'b0;
            capOk     <= 1'b0;
        end else begin
            hresp <= 1'b0;  // Always OKAY
            case (state)
                BUS_IDLE: begin
                    wrPending <= accept && hwrite;
                    if (accept) begin
                        capIdx <= aIdx;
                        capHi  <= haddr[HI_BIT];
                        capOk  <= addrOk;
                    end
                    // Read: stall one cycle
                    if (accept && !hwrite) begin
                        hreadyout <= 1'b0;
                        state     <= BUS_READ;
                    end
                end
                BUS_READ: begin
                    hrdata    <= rdWord;
                    hreadyout <= 1'b1;
                    wrPending <= 1'b0;
                    state     <= BUS_IDLE;
                end
                default: begin
                    hreadyout <= 1'b1;
                    wrPending <= 1'b0;
                    state     <= BUS_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    // Whole-register writes land half by half; unmapped writes drop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            offCfg    <= '0;
            fixedCtrl <= RESET_REG;
            globalEn  <= RESET_REG;
        end else begin
            if (wrCfg0) begin
                offCfg[0] <= put_word(offCfg[0], capHi, hwdata);
            end
            if (wrCfg1) begin
                offCfg[1] <= put_word(offCfg[1], capHi, hwdata);
            end
            if (wrFixCtl) begin
                fixedCtrl <= put_word(fixedCtrl, capHi, hwdata);
            end
            if (wrGlobal) begin
                globalEn <= put_word(globalEn, capHi, hwdata);
            end
        end
    end

    // ****************************************************************
    // Fixed counter: retired instructions of both threads
    // ****************************************************************
    // Gating is a plain AND sampled every edge, so enabling local
    // bits before the global bit cannot leak extra counts
    wire fixLocal = fixedCtrl[FIX_EN_LO] | fixedCtrl[FIX_EN_HI];
    wire fixRun   = fixLocal & globalEn[GLB_FIXED_BIT];
    wire [INC_W-1:0] fixInc = INC_W'(ev.retired[0])
                            + INC_W'(ev.retired[1]);

    event_counter #(.CNT_W(CNT_W)) u_fixed (
        .clk    (clk),
        .rst_n  (rst_n),
        .enable (fixRun),
        .inc    (fixInc),
        .loadLo (wrFixCnt && !capHi),
        .loadHi (wrFixCnt && capHi),
        .wdata  (hwdata),
        .count  (cnt[0])
    );

    // ****************************************************************
    // Programmable counters
    // ****************************************************************
    logic [NPROG-1:0][63:0] rdSel;  // Read contributions, selects
    logic [NPROG-1:0][63:0] rdPmc;  // Read contributions, counters

    genvar g;
    generate
        for (g = 0; g < NPROG; g = g + 1) begin : g_prog
            wire [7:0] code  = evSel[g][SEL_CODE_LSB +: 8];
            wire [7:0] umask = evSel[g][SEL_UMASK_LSB +: 8];
            wire       thr   = evSel[g][SEL_THREAD];
            wire wrS = wrLive && capIdx == IDX_EVSEL_BASE + 10'(g);
            wire wrC = wrLive && capIdx == IDX_PMC_BASE + 10'(g);

            // Off-core match: thread, any selected request type and
            // any selected response attribute
            wire m0 = |(ev.offReq  & offCfg[0][REQ_LSB +: SEL_W])
                    & |(ev.offResp & offCfg[0][RESP_LSB +: SEL_W]);
            wire m1 = |(ev.offReq  & offCfg[1][REQ_LSB +: SEL_W])
                    & |(ev.offResp & offCfg[1][RESP_LSB +: SEL_W]);
            wire offHit = ev.offValid && ev.offThread == thr
                        && umask == UM_OFFCORE;
            wire isRet  = code == EV_RETIRED && umask == UM_RETIRED;
            wire isUops = code == EV_UOPS && umask == UM_UOPS;

            // Event selection; unknown codes count nothing
            wire [INC_W-1:0] inc =
                isRet  ? INC_W'(ev.retired[thr]) :
                isUops ? INC_W'(ev.uops[thr]) :
                (offHit && code == EV_OFFCORE0 && m0) ? INC_W'(1) :
                (offHit && code == EV_OFFCORE1 && m1) ? INC_W'(1) :
                '0;

            // Select register
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    evSel[g] <= RESET_REG;
                end else if (wrS) begin
                    evSel[g] <= put_word(evSel[g], capHi, hwdata);
                end
            end

            event_counter #(.CNT_W(CNT_W)) u_pmc (
                .clk    (clk),
                .rst_n  (rst_n),
                .enable (evSel[g][SEL_ENABLE] & globalEn[g]),
                .inc    (inc),
                .loadLo (wrC && !capHi),
                .loadHi (wrC && capHi),
                .wdata  (hwdata),
                .count  (cnt[g+1])
            );

            // Read contributions, zero when not addressed
            assign rdSel[g] = (capIdx == IDX_EVSEL_BASE + 10'(g))
                            ? evSel[g] : RESET_REG;
            assign rdPmc[g] = (capIdx == IDX_PMC_BASE + 10'(g))
                            ? 64'(cnt[g+1]) : RESET_REG;
        end
    endgenerate

    // ****************************************************************
    // Read selection
    // ****************************************************************
    logic [63:0] rdProg;  // OR of addressed programmable registers

    // At most one index matches, so an OR tree is enough
    always_comb begin
        rdProg = RESET_REG;
        for (int i = 0; i < NPROG; i++) begin
            rdProg = rdProg | rdSel[i] | rdPmc[i];
        end
    end

    wire [63:0] rdFixed =
        (capIdx == IDX_OFFCORE_CFG0) ? offCfg[0] :
        (capIdx == IDX_OFFCORE_CFG1) ? offCfg[1] :
        (capIdx == IDX_FIXED_CTR)    ? 64'(cnt[0]) :
        (capIdx == IDX_FIXED_CTRL)   ? fixedCtrl :
        (capIdx == IDX_GLOBAL_EN)    ? globalEn : RESET_REG;
    wire [63:0] rd64   = capOk ? (rdFixed | rdProg) : RESET_REG;
    assign rdWord = capHi ? rd64[63:32] : rd64[31:0];

endmodule : perf_event_counters

`default_nettype wire

// *** perf_event_pkg.sv ***
package perf_event_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [9:0]  IDX_OFFCORE_CFG0 = 10'h1a6;
    localparam logic [9:0]  IDX_OFFCORE_CFG1 = 10'h1a7;
    localparam logic [9:0]  IDX_FIXED_CTR    = 10'h309;
    localparam logic [9:0]  IDX_FIXED_CTRL   = 10'h38d;
    localparam logic [9:0]  IDX_GLOBAL_EN    = 10'h38f;
    localparam logic [9:0]  IDX_EVSEL_BASE   = 10'h100;
    localparam logic [9:0]  IDX_PMC_BASE     = 10'h200;

    // ****************************************************************
    // Address layout on the bus
    // ****************************************************************
    localparam int unsigned IDX_LSB   = 2;   // Word index starts here
    localparam int unsigned IDX_MSB   = 11;
    localparam int unsigned HI_BIT    = 12;  // Selects upper 32 bits
    localparam int unsigned TOP_LSB   = 13;  // This bit and above must be zero
    localparam logic [2:0]  SIZE_WORD = 3'h2;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [63:0] RESET_REG  = 64'h0;

    // ****************************************************************
    // Event codes and unit masks
    // ****************************************************************
    localparam logic [7:0] EV_RETIRED  = 8'hc0;
    localparam logic [7:0] UM_RETIRED  = 8'h00;
    localparam logic [7:0] EV_UOPS     = 8'hb1;
    localparam logic [7:0] UM_UOPS     = 8'h01;
    localparam logic [7:0] EV_OFFCORE0 = 8'hb7;
    localparam logic [7:0] EV_OFFCORE1 = 8'hbb;
    localparam logic [7:0] UM_OFFCORE  = 8'h01;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int unsigned FIX_EN_LO     = 0;   // Local enable bits
    localparam int unsigned FIX_EN_HI     = 1;
    localparam int unsigned GLB_FIXED_BIT = 32;  // Global fixed gate
    localparam int unsigned SEL_CODE_LSB  = 0;
    localparam int unsigned SEL_UMASK_LSB = 8;
    localparam int unsigned SEL_THREAD    = 16;
    localparam int unsigned SEL_ENABLE    = 22;
    localparam int unsigned REQ_LSB       = 0;
    localparam int unsigned RESP_LSB      = 16;
    localparam int unsigned SEL_W         = 16;

    // Request type bits of the off-core configuration
    localparam int unsigned REQ_CORE_WRITEBACK   = 3;
    localparam int unsigned REQ_L3_DATA_PREFETCH = 7;
    localparam int unsigned REQ_L3_OWN_PREFETCH  = 8;
    localparam int unsigned REQ_L3_CODE_PREFETCH = 9;
    localparam int unsigned REQ_SPLIT_UC_LOCK    = 10;
    localparam int unsigned REQ_STREAMING_STORE  = 11;

    // ****************************************************************
    // Core event carrier
    // ****************************************************************
    localparam int unsigned EVT_W = 3;  // Up to 7 per thread per cycle
    localparam int unsigned INC_W = 4;  // Room for two threads summed

    typedef struct packed {
        logic [1:0][EVT_W-1:0] retired;  // Retired this cycle, per thread
        logic [1:0][EVT_W-1:0] uops;     // Micro-ops executed, per thread
        logic                  offValid; // One off-core response
        logic                  offThread;
        logic [SEL_W-1:0]      offReq;   // One-hot request type
        logic [SEL_W-1:0]      offResp;  // Response attributes
    } core_events_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_READ = 2'b10
    } bus_state_t;

    // Replace one 32-bit half of a 64-bit register
    function automatic logic [63:0] put_word(input logic [63:0] old,
                                             input logic        hi,
                                             input logic [31:0] d);
        logic [63:0] r;
        r = old;
        if (hi) begin
            r[63:32] = d;
        end else begin
            r[31:0] = d;
        end
        return r;
    endfunction : put_word

endpackage : perf_event_pkg

// *** event_counter.sv ***
`timescale 1ns/1ns
`default_nettype none

module event_counter
    import perf_event_pkg::*;
#(
    parameter int unsigned CNT_W = 48
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Counting
    input  wire logic             enable,
    input  wire logic [INC_W-1:0] inc,
    // Software load
    input  wire logic             loadLo,
    input  wire logic             loadHi,
    input  wire logic [31:0]      wdata,
    // Count
    output logic      [CNT_W-1:0] count
);

    // ****************************************************************
    // Counter register
    // ****************************************************************
    logic [CNT_W-1:0] next_count;  // Value for the next edge

    // A software load of either half wins over counting in the same cycle;
    // that cycle's increment is dropped and the other half keeps its value
    always_comb begin
        next_count = count;
        if (loadLo) begin
            next_count[31:0] = wdata;
        end else if (loadHi) begin
            next_count[CNT_W-1:32] = wdata[CNT_W-33:0];
        end else if (enable) begin
            next_count = count + CNT_W'(inc);
        end
    end

    // Register update
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule : event_counter

`default_nettype wire

// *** perf_event_counters_chk.sv ***
`timescale 1ns/1ns
`default_nettype none

module perf_event_counters_chk
    import perf_event_pkg::*;
#(
    parameter int unsigned CNT_W = 48   // Counter width, as in the design
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AHB-Lite slave side
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic        hreadyout,
    input  wire logic [31:0] hrdata,
    input  wire logic        hresp
);
    // ****************************************************************
    // Decoded bus events
    // ****************************************************************
    wire take   = hsel && hready && (htrans == HTRANS_NONSEQ);  // Accepted
    wire rdTake = take && !hwrite;                              // Read
    wire wrTake = take && hwrite;                               // Write
    // Refused read: high address bits or a non-word size
    wire badRd  = rdTake && ((haddr[31:13] != '0) || (hsize != SIZE_WORD));
    // Read of index zero, which no register occupies
    wire nullRd = rdTake && (haddr == 32'h0000_0000);
    // Upper half of the fixed counter, its spare bits must read zero
    wire hiCtr  = rdTake && (haddr == 32'h0000_1c24) && (hsize == SIZE_WORD);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("slave answered with an error response");
    a_read_wait: assert property (rdTake |=> !hreadyout)
        else $error("read did not insert its single wait cycle");
    a_read_done: assert property (rdTake |-> ##2 hreadyout)
        else $error("read did not finish two edges after its address");
    a_write_nowait: assert property (wrTake |=> hreadyout)
        else $error("write stalled the bus");
    a_refused_zero: assert property (badRd |-> ##2 hrdata == RESET_WORD)
        else $error("refused read returned nonzero data");
    a_unmapped_zero: assert property (nullRd |-> ##2 hrdata == 32'h0)
        else $error("unmapped read returned nonzero data");
    a_ctr_width: assert property (hiCtr |-> ##2 hrdata[31:CNT_W-32] == '0)
        else $error("counter bits above its width read nonzero");
    // Read data only moves as the answer to a read taken two edges back
    a_data_hold: assert property (!$stable(hrdata) |-> $past(rdTake, 2))
        else $error("read data changed without a read");

    cover property (rdTake);
    cover property (wrTake);
    cover property (badRd);
endmodule : perf_event_counters_chk

bind perf_event_counters perf_event_counters_chk #(.CNT_W(CNT_W))
    perf_event_counters_chk_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp));

`default_nettype wire

// *** perf_event_counters_bench.sv ***
`timescale 1ns/1ns
`default_nettype none

module perf_event_counters_bench
    import perf_event_pkg::*;
;
    localparam int          CW   = 48;                  // Counter width
    localparam logic [63:0] MASK = (64'h1 << CW) - 1;   // Counter bits
    logic         clk, rst_n, hsel, hwrite;             // Clock, reset, bus
    logic [31:0]  haddr, hwdata;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [2:0]   sz = SIZE_WORD;                       // Size for next transfer
    core_events_t ev;                                   // Core events
    wire  logic        hreadyout, hresp;
    wire  logic [31:0] hrdata;
    logic [63:0]  mdl [1024];                           // Reference registers
    int           nMismatch = 0;
    int           checkCount = 0;
    int           reqBits [6] = '{3, 7, 8, 9, 10, 11};  // Named request types
    logic [15:0]  evTab [4];                            // {unit mask, code}
    logic [9:0]   regList [8];
    logic [31:0]  q;

    perf_event_counters #(.CNT_W(CW)) perf_event_counters_inst (
        .clk(clk), .rst_n(rst_n), .ev(ev), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp));

    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    task automatic summarize();
        if (nMismatch == 0 && checkCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One single transfer; address held until hreadyout is seen high
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= sz;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        check("response", {31'h0, hresp}, 32'h0);
    endtask : xfer

    // Both halves, low word first; the model keeps only what is stored
    task automatic wr64(input logic [9:0] idx, input logic [63:0] v);
        logic [31:0] r;
        xfer(1'b1, {20'h0, idx, 2'b00}, v[31:0], r);
        xfer(1'b1, {20'h0, idx, 2'b00} | 32'h1000, v[63:32], r);
        mdl[idx] = (idx == IDX_FIXED_CTR || idx[9:8] == 2'h2) ? v & MASK : v;
    endtask : wr64

    task automatic rd64(input logic [9:0] idx);
        logic [31:0] r;
        xfer(1'b0, {20'h0, idx, 2'b00}, 32'h0, r);
        check($sformatf("index %h low", idx), r, mdl[idx][31:0]);
        xfer(1'b0, {20'h0, idx, 2'b00} | 32'h1000, 32'h0, r);
        check($sformatf("index %h high", idx), r, mdl[idx][63:32]);
    endtask : rd64

    // Random events for n cycles, counted by the model as they are sampled
    task automatic run(input int n);
        core_events_t e;
        logic [63:0]  s;
        int           inc;
        logic         th;
        for (int c = 0; c < n; c++) begin
            @(posedge clk);
            for (int t = 0; t < 2; t++) begin
                e.retired[t] = 3'($urandom);
                e.uops[t]    = 3'($urandom);
            end
            e.offValid  = 1'($urandom);
            e.offThread = 1'($urandom);
            e.offReq    = 16'h1 << reqBits[$urandom % 6];
            e.offResp   = 16'($urandom);
            ev <= e;
            if ((mdl[IDX_FIXED_CTRL][1:0] != 2'b00)
                && mdl[IDX_GLOBAL_EN][32]) begin
                mdl[IDX_FIXED_CTR] = (mdl[IDX_FIXED_CTR] + 64'(e.retired[0])
                                      + 64'(e.retired[1])) & MASK;
            end
            for (int p = 0; p < 2; p++) begin
                s   = mdl[IDX_EVSEL_BASE + 10'(p)];
                th  = s[16];
                inc = 0;
                case ({s[15:8], s[7:0]})
                    evTab[0]: inc = int'(e.retired[th]);
                    evTab[1]: inc = int'(e.uops[th]);
                    evTab[2]: inc = int'(e.offValid && e.offThread == th
                        && (e.offReq & mdl[IDX_OFFCORE_CFG0][15:0]) != 0
                        && (e.offResp & mdl[IDX_OFFCORE_CFG0][31:16]) != 0);
                    evTab[3]: inc = int'(e.offValid && e.offThread == th
                        && (e.offReq & mdl[IDX_OFFCORE_CFG1][15:0]) != 0
                        && (e.offResp & mdl[IDX_OFFCORE_CFG1][31:16]) != 0);
                    default: inc = 0;
                endcase
                if (s[22] && mdl[IDX_GLOBAL_EN][p]) begin
                    mdl[IDX_PMC_BASE + 10'(p)] =
                        (mdl[IDX_PMC_BASE + 10'(p)] + 64'(inc)) & MASK;
                end
            end
        end
        @(posedge clk);
        ev <= '0;
    endtask : run

    // ****************************************************************
    // Clock, watchdog and tests
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run is under two thousand cycles; this leaves ample margin
    initial begin
        #500_000;
        nMismatch++;
        summarize();
    end

    initial begin
        {rst_n, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
        ev = '0;
        foreach (mdl[i]) mdl[i] = 64'h0;
        evTab   = '{{UM_RETIRED, EV_RETIRED}, {UM_UOPS, EV_UOPS},
                    {UM_OFFCORE, EV_OFFCORE0}, {UM_OFFCORE, EV_OFFCORE1}};
        regList = '{IDX_OFFCORE_CFG0, IDX_OFFCORE_CFG1, IDX_FIXED_CTR,
                    IDX_FIXED_CTRL, IDX_GLOBAL_EN, IDX_EVSEL_BASE,
                    IDX_PMC_BASE, IDX_PMC_BASE + 10'h1};
        void'($urandom(37));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        foreach (regList[i]) rd64(regList[i]);
        // Fixed counter: every local enable code, global bit set both orders
        for (int ctl = 0; ctl < 4; ctl++) begin
            for (int ord = 0; ord < 2; ord++) begin
                wr64(IDX_GLOBAL_EN, 64'h0);
                wr64(IDX_FIXED_CTRL, 64'h0);
                wr64(IDX_FIXED_CTR, 64'h0);
                if (ord == 0) wr64(IDX_GLOBAL_EN, 64'h1 << 32);
                wr64(IDX_FIXED_CTRL, 64'(ctl));
                if (ord == 1) wr64(IDX_GLOBAL_EN, 64'h1 << 32);
                run(20 + ($urandom % 20));
                rd64(IDX_FIXED_CTR);
            end
        end
        // Local enable without the global gate must hold the count
        wr64(IDX_GLOBAL_EN, 64'h0);
        run(25);
        rd64(IDX_FIXED_CTR);
        // Programmable events, both threads, loads near the 32-bit carry
        for (int k = 0; k < 4; k++) begin
            for (int t = 0; t < 2; t++) begin
                wr64(IDX_OFFCORE_CFG0, {32'h0, 16'($urandom) | 16'h1,
                     16'h1 << reqBits[(2 * k + t) % 6]});
                wr64(IDX_OFFCORE_CFG1, {32'h0, 16'($urandom) | 16'h1,
                     16'h1 << reqBits[(2 * k + t + 3) % 6]});
                wr64(IDX_EVSEL_BASE, (64'(t) << 16) | (64'h1 << 22)
                     | 64'(evTab[k]));
                wr64(IDX_EVSEL_BASE + 10'h1, (64'(1 - t) << 16)
                     | (64'h1 << 22) | 64'(evTab[(k + 1) % 4]));
                wr64(IDX_GLOBAL_EN, (k == 3) ? 64'h1 : 64'h3);
                wr64(IDX_PMC_BASE, 64'hffff_ffc0);
                run(40);
                rd64(IDX_PMC_BASE);
                rd64(IDX_PMC_BASE + 10'h1);
            end
        end
        // Refused write size, refused high address, unmapped index
        sz = 3'h0;
        xfer(1'b1, 32'h0000_0c24, 32'h1234_5678, q);
        sz = SIZE_WORD;
        rd64(IDX_FIXED_CTR);
        xfer(1'b0, 32'h0002_0c24, 32'h0, q);
        check("high address read", q, 32'h0);
        rd64(10'h000);
        summarize();
    end
endmodule : perf_event_counters_bench

`default_nettype wire
